// ### logic/vpic_pkg.sv
package vpic_pkg;
    localparam int NUM_SRC   = 32;
    localparam int NUM_LVL   = 8;
    localparam int STK_DEPTH = 8;

    // register byte offsets
    localparam logic [7:0] SMR_BASE     = 8'h00; // 32 words, source mode
    localparam logic [7:0] OFF_IVR      = 8'h80; // vector_read_reg
    localparam logic [7:0] OFF_FVR      = 8'h84;
    localparam logic [7:0] OFF_ISR      = 8'h88;
    localparam logic [7:0] OFF_IPR      = 8'h8c;
    localparam logic [7:0] OFF_IMR      = 8'h90;
    localparam logic [7:0] OFF_CISR     = 8'h94;
    localparam logic [7:0] OFF_IECR     = 8'h98;
    localparam logic [7:0] OFF_IDCR     = 8'h9c;
    localparam logic [7:0] OFF_ICCR     = 8'ha0;
    localparam logic [7:0] OFF_ISCR     = 8'ha4;
    localparam logic [7:0] OFF_EOICR    = 8'ha8; // end_of_service_cmd
    localparam logic [7:0] OFF_FFER     = 8'hac; // fast_redirect set
    localparam logic [7:0] OFF_FFDR     = 8'hb0; // fast_redirect clear
    localparam logic [7:0] OFF_FFSR     = 8'hb4;
    localparam logic [7:0] OFF_WAKE     = 8'hb8; // wake_only_mask
    localparam logic [7:0] OFF_EXTMAP   = 8'hbc; // 1 = external source

    // source mode word fields
    localparam int SMR_PRIO_LSB = 0;  // priority_level_field [2:0]
    localparam int SMR_TYPE_LSB = 5;  // [6:5]

    localparam logic [1:0] TYPE_LVL_LOW  = 2'h0; // internal: level
    localparam logic [1:0] TYPE_EDGE_NEG = 2'h1; // internal: edge
    localparam logic [1:0] TYPE_LVL_HIGH = 2'h2;
    localparam logic [1:0] TYPE_EDGE_POS = 2'h3;

    localparam logic [31:0] EXTMAP_RST  = 32'h0000_0001;
    localparam logic [7:0]  SMR_RST     = 8'h00;
    localparam logic [4:0]  SPURIOUS_ID = 5'h00;
endpackage

// ### logic/vpic_src_stage.sv
`timescale 1ns/1ns
`default_nettype none
// one source: synchroniser, mode selection, edge memory, pending bit
module vpic_src_stage (
    // clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    // raw line and configuration
    input  wire logic       line_in,
    input  wire logic       external_in,
    input  wire logic [1:0] mode_in,
    // software commands
    input  wire logic       sw_set_in,
    input  wire logic       sw_clr_in,
    input  wire logic       auto_clr_in,
    // status
    output logic            pending_out
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic edge_reg;
    logic is_edge;
    logic active_hi;
    logic lvl;
    logic hit;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
        end else begin
            sync1_reg <= line_in; // [R3]
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // internal lines are active high whatever the polarity code says
    always_comb begin
        is_edge   = mode_in[0]; // [R5]
        active_hi = !external_in || mode_in[1]; // [R6]
        lvl       = active_hi ? sync2_reg : !sync2_reg;
        hit       = active_hi ? (sync2_reg && !prev_reg)
                              : (!sync2_reg && prev_reg);
    end

    // detection wins over a clear in the same cycle
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            edge_reg <= 1'b0;
        end else if (!is_edge) begin
            edge_reg <= 1'b0; // [R18]
        end else if (hit || sw_set_in) begin
            edge_reg <= 1'b1;
        end else if (sw_clr_in || auto_clr_in) begin
            edge_reg <= 1'b0;
        end
    end

    assign pending_out = is_edge ? edge_reg : lvl;
endmodule
`default_nettype wire

// ### logic/vpic_prio_stack.sv
`timescale 1ns/1ns
`default_nettype none
// nesting stack of serviced source number and level
module vpic_prio_stack (
    // clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    // commands
    input  wire logic       push_in,
    input  wire logic       pop_in,
    input  wire logic [4:0] push_id_in,
    input  wire logic [2:0] push_lvl_in,
    // top of stack
    output logic            busy_out,
    output logic [4:0]      cur_id_out,
    output logic [2:0]      cur_lvl_out
);
    logic [4:0] id_mem  [vpic_pkg::STK_DEPTH];
    logic [2:0] lvl_mem [vpic_pkg::STK_DEPTH];
    logic [3:0] cnt_reg;

    // a ninth push is dropped; eight levels cannot legally nest deeper
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_reg <= 4'h0; // [R22]
        end else if (push_in && cnt_reg != 4'(vpic_pkg::STK_DEPTH)) begin
            cnt_reg <= cnt_reg + 4'h1; // [R20]
        end else if (pop_in && cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1; // [R20]
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (push_in && cnt_reg != 4'(vpic_pkg::STK_DEPTH)) begin
            id_mem[cnt_reg[2:0]]  <= push_id_in;
            lvl_mem[cnt_reg[2:0]] <= push_lvl_in;
        end
    end

    assign busy_out    = cnt_reg != 4'h0;
    assign cur_id_out  = busy_out ? id_mem[3'(cnt_reg - 4'h1)] : 5'h00;
    assign cur_lvl_out = busy_out ? lvl_mem[3'(cnt_reg - 4'h1)] : 3'h0;
endmodule
`default_nettype wire

// ### logic/vpic_top.sv
// Functional notes
// [R1] thirty-two maskable vectored sources, eight levels
// [R2] drives fast and normal active-low requests
// [R3] sources take peripheral and pin interrupts
// [R4] higher level preempts lower level in service
// [R5] internal sources: level or edge
// [R6] external: rising, falling, high, low
// [R7] fast_redirect routes source to fast request
// [R8] always clocked, no power gating dependence
// [R9] either request wakes idle processor
// [R10] wake_only_mask wakes without request line
// [R11] source 0 is the fast pin
// [R12] source 1 ORs system peripheral lines
// [R13] software polls system peripherals for cause
// [R14] sources 2-31 peripheral or external lines
// [R15] parallel io interrupts only on 2-31
// [R16] source number equals peripheral identifier
// [R17] software configures multiplexed interrupt pins
// [R18] set/clear affect edge sources only
// [R19] level 7 highest; ties to lowest number
// [R20] vector read pushes, end command pops stack
// [R21] normal request only above current level
// [R22] outputs registered, reset clears all state; the stack entries id_mem and lvl_mem are not reset
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module vpic_top (
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    // ahb-lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic [31:0]      hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // interrupt sources
    input  wire logic        fast_interrupt_pin_in,
    input  wire logic [3:0]  system_lines_in,
    input  wire logic [31:2] peripheral_sources_in,
    // processor side
    output logic             fast_request_n_out,
    output logic             normal_request_n_out,
    output logic             wake_out
);
    // bus address phase capture
    logic        wr_pend_reg;
    logic        rd_pend_reg;
    logic [7:0]  addr_reg;
    logic        ap_valid;
    logic [31:0] hrdata_reg;

    // configuration
    logic [7:0]  smr_reg [vpic_pkg::NUM_SRC];
    logic [31:0] enable_reg;
    logic [31:0] redirect_reg;
    logic [31:0] extmap_reg;
    logic        wake_mask_reg;

    // source stage
    logic [31:0] raw_line;
    logic [31:0] pending;
    logic [31:0] sw_set;
    logic [31:0] sw_clr;
    logic [31:0] auto_clr;

    // priority
    logic        stk_busy;
    logic [4:0]  stk_id;
    logic [2:0]  stk_lvl;
    logic        best_valid;
    logic [4:0]  best_id;
    logic [2:0]  best_lvl;
    logic        do_push;
    logic        do_pop;
    logic [31:0] fast_cand;
    logic        normal_want;
    logic        fast_want;

    logic        fast_n_reg;
    logic        normal_n_reg;
    logic        wake_reg;

    function automatic logic [2:0] prio_of(input logic [7:0] smr);
        prio_of = smr[vpic_pkg::SMR_PRIO_LSB +: 3];
    endfunction

    function automatic logic [1:0] type_of(input logic [7:0] smr);
        type_of = smr[vpic_pkg::SMR_TYPE_LSB +: 2];
    endfunction

    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] o);
        is_reg = (a == o);
    endfunction

    assign ap_valid = hsel_in && htrans_in[1] && hready_in;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
        end else begin
            wr_pend_reg <= ap_valid && hwrite_in;
            rd_pend_reg <= ap_valid && !hwrite_in;
            if (ap_valid) begin
                addr_reg <= haddr_in[7:0];
            end
        end
    end

    // source wiring
    always_comb begin
        raw_line       = {peripheral_sources_in, 2'b00};
        raw_line[0]    = fast_interrupt_pin_in; // [R11]
        raw_line[1]    = |system_lines_in; // [R12]
    end

    // command strobes, one-cycle pulses in the data phase
    always_comb begin
        sw_set = 32'h0000_0000;
        sw_clr = 32'h0000_0000;
        if (wr_pend_reg && is_reg(addr_reg, vpic_pkg::OFF_ISCR)) begin
            sw_set = hwdata_in; // [R18]
        end
        if (wr_pend_reg && is_reg(addr_reg, vpic_pkg::OFF_ICCR)) begin
            sw_clr = hwdata_in; // [R18]
        end
    end

    // vector read clears only the current edge source; redirected ones excluded
    always_comb begin
        auto_clr = 32'h0000_0000;
        if (do_push && !redirect_reg[best_id]) begin
            auto_clr[best_id] = 1'b1;
        end
        if (rd_pend_reg && is_reg(addr_reg, vpic_pkg::OFF_FVR)) begin
            auto_clr[0] = 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < vpic_pkg::NUM_SRC; g++) begin : g_src
            vpic_src_stage u_stage (
                .clk_sys_in  (clk_sys_in),
                .rst_in      (rst_in),
                .line_in     (raw_line[g]),
                .external_in (extmap_reg[g]), // [R6]
                .mode_in     (type_of(smr_reg[g])), // [R5]
                .sw_set_in   (sw_set[g]),
                .sw_clr_in   (sw_clr[g]),
                .auto_clr_in (auto_clr[g]),
                .pending_out (pending[g])
            );
        end
    endgenerate

    // configuration registers
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < vpic_pkg::NUM_SRC; i++) begin
                smr_reg[i] <= vpic_pkg::SMR_RST;
            end
            enable_reg    <= 32'h0000_0000; // [R22]
            redirect_reg  <= 32'h0000_0000;
            extmap_reg    <= vpic_pkg::EXTMAP_RST;
            wake_mask_reg <= 1'b0;
        end else if (wr_pend_reg) begin
            if (addr_reg < vpic_pkg::OFF_IVR) begin
                smr_reg[addr_reg[6:2]] <= hwdata_in[7:0]; // [R1]
            end
            unique case (addr_reg)
                vpic_pkg::OFF_IECR: enable_reg <= enable_reg | hwdata_in;
                vpic_pkg::OFF_IDCR: enable_reg <= enable_reg & ~hwdata_in;
                vpic_pkg::OFF_FFER: begin
                    redirect_reg <= redirect_reg | hwdata_in; // [R7]
                end
                vpic_pkg::OFF_FFDR: begin
                    redirect_reg <= redirect_reg & ~hwdata_in; // [R7]
                end
                vpic_pkg::OFF_WAKE: wake_mask_reg <= hwdata_in[0]; // [R10]
                // source 0 and 1 wiring is fixed: source 0 always external, source 1 internal; only 2-31 selectable
                vpic_pkg::OFF_EXTMAP: begin
                    extmap_reg <= {hwdata_in[31:2], 2'b01}; // [R14] [R15]
                end
                default: ;
            endcase
        end
    end

    // priority resolution over normal candidates 1-31
    always_comb begin
        best_valid = 1'b0;
        best_id    = vpic_pkg::SPURIOUS_ID;
        best_lvl   = 3'h0;
        for (int i = 1; i < vpic_pkg::NUM_SRC; i++) begin
            if (pending[i] && enable_reg[i] && !redirect_reg[i]) begin
                if (!best_valid || prio_of(smr_reg[i]) > best_lvl) begin
                    best_valid = 1'b1; // [R19]
                    best_id    = 5'(i);
                    best_lvl   = prio_of(smr_reg[i]);
                end
            end
        end
    end

    // strictly above the level in service, or anything when idle
    assign normal_want = best_valid
                         && (!stk_busy || best_lvl > stk_lvl); // [R4] [R21]
    assign fast_cand   = pending & enable_reg
                         & (redirect_reg | 32'h0000_0001); // [R7]
    assign fast_want   = |fast_cand;

    // an ivr read with nothing above the level gives the spurious id
    assign do_push = rd_pend_reg && is_reg(addr_reg, vpic_pkg::OFF_IVR)
                     && normal_want; // [R20]
    assign do_pop  = wr_pend_reg && is_reg(addr_reg, vpic_pkg::OFF_EOICR);

    vpic_prio_stack u_stack (
        .clk_sys_in  (clk_sys_in),
        .rst_in      (rst_in),
        .push_in     (do_push),
        .pop_in      (do_pop),
        .push_id_in  (best_id),
        .push_lvl_in (best_lvl),
        .busy_out    (stk_busy),
        .cur_id_out  (stk_id),
        .cur_lvl_out (stk_lvl)
    );

    // request outputs; clock never gated so this runs in idle too
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            fast_n_reg   <= 1'b1; // [R22]
            normal_n_reg <= 1'b1;
            wake_reg     <= 1'b0;
        end else begin
            fast_n_reg   <= !(fast_want && !wake_mask_reg); // [R2] [R8]
            normal_n_reg <= !(normal_want && !wake_mask_reg); // [R21] [R10]
            wake_reg   <= fast_want || normal_want; // [R9] [R10]
        end
    end

    assign fast_request_n_out   = fast_n_reg;
    assign normal_request_n_out = normal_n_reg;
    assign wake_out             = wake_reg;

    // read data registered at the end of the address phase
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (ap_valid && !hwrite_in) begin
            hrdata_reg <= 32'h0000_0000;
            if (haddr_in[7:0] < vpic_pkg::OFF_IVR) begin
                hrdata_reg <= {24'h00_0000, smr_reg[haddr_in[6:2]]};
            end else begin
                unique case (haddr_in[7:0])
                    vpic_pkg::OFF_IVR: begin
                        hrdata_reg <= {27'h0, normal_want ? best_id
                                                     : vpic_pkg::SPURIOUS_ID};
                    end
                    vpic_pkg::OFF_FVR:  hrdata_reg <= 32'h0000_0000;
                    vpic_pkg::OFF_ISR:  hrdata_reg <= {27'h0, stk_id}; // [R16]
                    vpic_pkg::OFF_IPR:  hrdata_reg <= pending;
                    vpic_pkg::OFF_IMR:  hrdata_reg <= enable_reg;
                    vpic_pkg::OFF_CISR: begin
                        hrdata_reg <= {30'h0, !normal_n_reg, !fast_n_reg};
                    end
                    vpic_pkg::OFF_FFSR: hrdata_reg <= redirect_reg;
                    vpic_pkg::OFF_WAKE: hrdata_reg <= {31'h0, wake_mask_reg};
                    vpic_pkg::OFF_EXTMAP: hrdata_reg <= extmap_reg;
                    default: hrdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign hrdata_out    = hrdata_reg;
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
endmodule
`default_nettype wire

// ### tb/vpic_checker.sv
`timescale 1ns/1ns
`default_nettype none
module vpic_checker (
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    // bus
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hrdata_out,
    input  wire logic        hreadyout_out,
    input  wire logic        hresp_out,
    // sources
    input  wire logic        fast_interrupt_pin_in,
    input  wire logic [3:0]  system_lines_in,
    input  wire logic [31:2] peripheral_sources_in,
    // processor side
    input  wire logic        fast_request_n_out,
    input  wire logic        normal_request_n_out,
    input  wire logic        wake_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    wire logic addr_ok = hsel_in && htrans_in[1] && hready_in;
    logic      wmask_pend;
    logic      wmask;
    // shadow of the wake-only bit, updated in the write data phase
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            wmask_pend <= 1'b0;
            wmask      <= 1'b0;
        end else begin
            wmask_pend <= addr_ok && hwrite_in
                && haddr_in == {24'h0, vpic_pkg::OFF_WAKE};
            if (wmask_pend) begin
                wmask <= hwdata_in[0];
            end
        end
    end
    chk_reset_idle: assert property (
        $fell(rst_in) |-> fast_request_n_out && normal_request_n_out
            && !wake_out) else $error("request active after reset");
    chk_wake_req: assert property (
        !fast_request_n_out || !normal_request_n_out |-> wake_out)
        else $error("request without wake");
    chk_bus_okay: assert property (
        hreadyout_out && !hresp_out) else $error("bus not ready or error");
    chk_unmapped_zero: assert property (
        addr_ok && !hwrite_in && haddr_in >= 32'h0000_00c0
            && haddr_in < 32'h0000_0100 |=> hrdata_out == 32'h0)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (
        !(addr_ok && !hwrite_in) |=> $stable(hrdata_out))
        else $error("read data changed without read");
    chk_mask_all: assert property (
        addr_ok && hwrite_in && haddr_in == {24'h0, vpic_pkg::OFF_IDCR}
            ##1 hwdata_in == 32'hffff_ffff
            |-> ##[1:3] fast_request_n_out && normal_request_n_out)
        else $error("request stays after disabling all");
    chk_req_quiet: assert property (
        (!addr_ok && $stable(fast_interrupt_pin_in)
            && $stable(system_lines_in)
            && $stable(peripheral_sources_in)) [*6]
            |=> $stable(fast_request_n_out) && $stable(normal_request_n_out)
            && $stable(wake_out)) else $error("request moved while quiet");
    chk_wake_only: assert property (
        wmask && $past(wmask, 3) |-> normal_request_n_out)
        else $error("normal request under wake-only mask");
endmodule
bind vpic_top vpic_checker u_chk (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .fast_interrupt_pin_in(fast_interrupt_pin_in),
    .system_lines_in(system_lines_in),
    .peripheral_sources_in(peripheral_sources_in),
    .fast_request_n_out(fast_request_n_out),
    .normal_request_n_out(normal_request_n_out), .wake_out(wake_out));
`default_nettype wire

// ### tb/vpic_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// core stand-in: a slow sleeper, wake must stand several edges to resume
module vpic_core_model #(
    parameter int WAKE_LAT = 3
) (
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    input  wire logic wake_in,
    input  wire logic sleep_in,
    output logic      idle_out
);
    int cnt;
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cnt      <= 0;
            idle_out <= 1'b0;
        end else if (sleep_in) begin
            cnt      <= 0;
            idle_out <= 1'b1;
        end else if (wake_in && idle_out) begin
            cnt <= cnt + 1;
            idle_out <= (cnt + 1 < WAKE_LAT);
        end
    end
endmodule
`default_nettype wire

// ### tb/tb_vectored_priority_interrupt_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module tb_vectored_priority_interrupt_ctrl;
    logic        clk    = 1'b0;
    logic        rst    = 1'b1;
    logic        hsel   = 1'b0;
    logic [31:0] haddr  = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        fpin   = 1'b0;
    logic [3:0]  system_source    = 4'h0;
    logic [31:2] per    = 30'h0;
    logic        sleep  = 1'b0;
    logic [31:0] q;
    wire logic [31:0] hrdata;
    wire logic        hrdy;
    wire logic        fast_n;
    wire logic        norm_n;
    wire logic        wake;
    wire logic        idle;
    int          err_count = 0;
    int          cmp_count = 0;
    int          t;
    vpic_top dut (.clk_sys_in(clk), .rst_in(rst), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
        .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(),
        .fast_interrupt_pin_in(fpin), .system_lines_in(system_source),
        .peripheral_sources_in(per), .fast_request_n_out(fast_n),
        .normal_request_n_out(norm_n), .wake_out(wake));
    vpic_core_model core (.clk_sys_in(clk), .rst_in(rst), .wake_in(wake),
        .sleep_in(sleep), .idle_out(idle));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // bounded wait on: 0 fast, 1 normal, 2 wake, 3 core idle, 4 bus ready
    task automatic await(input int sel, input logic v);
        logic s;
        for (int n = 0; n < 40; n++) begin
            @(posedge clk);
            s = sel == 0 ? fast_n : sel == 1 ? norm_n : sel == 2 ? wake
                : sel == 3 ? idle : hrdy;
            if (s === v) begin
                return;
            end
        end
        err_count++;
        summarize();
    endtask
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        await(4, 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        await(4, 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        check(q, e);
    endtask
    task automatic rdbit(input logic [7:0] a, input int b, input logic e);
        xfer(a, 1'b0, 32'h0);
        check({31'h0, q[b]}, {31'h0, e});
    endtask
    task automatic cfg(input int n, input logic [1:0] ty, input int p);
        wr(8'(n * 4), (32'(ty) << vpic_pkg::SMR_TYPE_LSB) | 32'(p));
    endtask
    task automatic nap;
        sleep <= 1'b1;
        @(posedge clk);
        sleep <= 1'b0;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(vpic_pkg::OFF_IMR, 32'h0);
        rd(vpic_pkg::OFF_EXTMAP, vpic_pkg::EXTMAP_RST);
        rd(8'hc0, 32'h0);
        cfg(1, vpic_pkg::TYPE_LVL_HIGH, 3);
        cfg(5, vpic_pkg::TYPE_LVL_HIGH, 3);
        cfg(31, vpic_pkg::TYPE_LVL_HIGH, 6);
        wr(vpic_pkg::OFF_IECR, 32'h8000_0022);
        per[5] <= 1'b1;
        system_source    <= 4'h4;
        await(1, 1'b0);
        rd(vpic_pkg::OFF_IVR, 32'h1);
        repeat (5) @(posedge clk);
        check({31'h0, norm_n}, 32'h1);
        per[31] <= 1'b1;
        await(1, 1'b0);
        rd(vpic_pkg::OFF_IVR, 32'h1f);
        rd(vpic_pkg::OFF_ISR, 32'h1f);
        per[31] <= 1'b0;
        system_source     <= 4'h0;
        repeat (5) @(posedge clk);
        wr(vpic_pkg::OFF_EOICR, 32'h0);
        rd(vpic_pkg::OFF_ISR, 32'h1);
        wr(vpic_pkg::OFF_EOICR, 32'h0);
        await(1, 1'b0);
        rd(vpic_pkg::OFF_IVR, 32'h5);
        // level source stays pending: set/clear commands must not touch it
        wr(vpic_pkg::OFF_ICCR, 32'h0000_0020);
        rdbit(vpic_pkg::OFF_IPR, 5, 1'b1);
        per[5] <= 1'b0;
        wr(vpic_pkg::OFF_EOICR, 32'h0);
        cfg(12, vpic_pkg::TYPE_EDGE_POS, 2);
        wr(vpic_pkg::OFF_ISCR, 32'h0000_1020);
        rdbit(vpic_pkg::OFF_IPR, 12, 1'b1);
        rdbit(vpic_pkg::OFF_IPR, 5, 1'b0);
        wr(vpic_pkg::OFF_ICCR, 32'h0000_1000);
        rdbit(vpic_pkg::OFF_IPR, 12, 1'b0);
        wr(vpic_pkg::OFF_IECR, 32'h0000_1000);
        per[12] <= 1'b1;
        await(1, 1'b0);
        per[12] <= 1'b0;
        rd(vpic_pkg::OFF_IVR, 32'hc);
        rdbit(vpic_pkg::OFF_IPR, 12, 1'b0);
        wr(vpic_pkg::OFF_EOICR, 32'h0);
        wr(vpic_pkg::OFF_FFER, 32'h0000_1000);
        wr(vpic_pkg::OFF_ISCR, 32'h0000_1000);
        await(0, 1'b0);
        check({31'h0, norm_n}, 32'h1);
        rd(vpic_pkg::OFF_CISR, 32'h0000_0001);
        rd(vpic_pkg::OFF_FFSR, 32'h0000_1000);
        wr(vpic_pkg::OFF_ICCR, 32'h0000_1000);
        await(0, 1'b1);
        nap();
        cfg(0, vpic_pkg::TYPE_EDGE_POS, 0);
        wr(vpic_pkg::OFF_IECR, 32'h0000_0001);
        fpin <= 1'b1;
        await(0, 1'b0);
        await(3, 1'b0);
        xfer(vpic_pkg::OFF_FVR, 1'b0, 32'h0);
        fpin <= 1'b0;
        await(0, 1'b1);
        wr(vpic_pkg::OFF_WAKE, 32'h1);
        nap();
        per[5] <= 1'b1;
        await(3, 1'b0);
        check({31'h0, norm_n}, 32'h1);
        wr(vpic_pkg::OFF_WAKE, 32'h0);
        await(1, 1'b0);
        per[5] <= 1'b0;
        await(1, 1'b1);
        wr(vpic_pkg::OFF_EXTMAP, 32'h0010_0001);
        for (t = 0; t < 4; t++) begin
            per[20] <= ~t[1];
            cfg(20, 2'(t), 0);
            repeat (5) @(posedge clk);
            wr(vpic_pkg::OFF_ICCR, 32'h0010_0000);
            rdbit(vpic_pkg::OFF_IPR, 20, 1'b0);
            per[20] <= t[1];
            repeat (5) @(posedge clk);
            rdbit(vpic_pkg::OFF_IPR, 20, 1'b1);
            per[20] <= ~t[1];
            repeat (5) @(posedge clk);
            rdbit(vpic_pkg::OFF_IPR, 20, t[0]);
        end
        wr(vpic_pkg::OFF_FFDR, 32'h0000_1000);
        rd(vpic_pkg::OFF_FFSR, 32'h0000_0000);
        wr(vpic_pkg::OFF_IDCR, 32'hffff_ffff);
        rd(vpic_pkg::OFF_IMR, 32'h0);
        rd(8'hfc, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
